// >>> ring_trip_checker.sv
// Port-level assertions for the ring trip detector
`default_nettype none
`include "ring_trip_defs.vh"
module ring_trip_checker (
    input wire logic        core_clk_i,
    input wire logic        rstn_i,
    input wire logic [3:0]  reg_addr_i,
    input wire logic [15:0] reg_wdata_i,
    input wire logic        reg_wr_i,
    input wire logic        reg_rd_i,
    input wire logic [15:0] reg_rdata_o,
    input wire logic [2:0]  linefeed_state_i,
    input wire logic        cadence_expire_i,
    input wire logic        mode_write_i,
    input wire logic        trip_detected_o,
    input wire logic        exit_req_o,
    input wire logic        exit_to_active_o,
    input wire logic        force_exit_o,
    input wire logic        irq_o
);
    // ==========
    // One domain: shared clock and reset
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!rstn_i);
    wire logic ring = (linefeed_state_i == `LFS_RINGING);   // Channel is ringing
    wire logic en_wr = reg_wr_i && (reg_addr_i == `REG_IRQ_EN); // Enable write
    // ==========
    // Properties
    property p_rd_slot; reg_rdata_o != 16'h0000 |-> $past(reg_rd_i); endproperty
    a_rd_slot: assert property (p_rd_slot) else $error("read data outside slot");
    property p_idle; (!ring)[*3] |-> !trip_detected_o; endproperty
    a_idle: assert property (p_idle) else $error("trip while not ringing");
    property p_trip_ring; $rose(trip_detected_o) |-> ring && $past(ring); endproperty
    a_trip_ring: assert property (p_trip_ring) else $error("trip rose off ring");
    property p_manual; ring && !exit_req_o && mode_write_i |=> exit_req_o && exit_to_active_o;
    endproperty
    a_manual: assert property (p_manual) else $error("manual exit wrong");
    property p_cad; ring && !exit_req_o && cadence_expire_i |=> exit_req_o; endproperty
    a_cad: assert property (p_cad) else $error("cadence exit missing");
    property p_hold; exit_req_o && ring |=> exit_req_o && $stable(exit_to_active_o); endproperty
    a_hold: assert property (p_hold) else $error("exit target changed");
    property p_clr; !ring |=> !exit_req_o && !force_exit_o; endproperty
    a_clr: assert property (p_clr) else $error("exit not cleared");
    property p_force; $rose(force_exit_o) |-> exit_req_o && $past(exit_req_o); endproperty
    a_force: assert property (p_force) else $error("force without exit");
    property p_mask; en_wr && reg_wdata_i[1:0] == 2'b00 ##1 !en_wr |=> !irq_o; endproperty
    a_mask: assert property (p_mask) else $error("irq high while masked");
    // ==========
    // Main scenarios reached
    c_trip: cover property ($rose(trip_detected_o));
    c_manual: cover property (ring && mode_write_i && !exit_req_o);
    c_force: cover property ($rose(force_exit_o));
    c_irq: cover property ($rose(irq_o));
endmodule
bind ring_trip_detector ring_trip_checker chk_u (.core_clk_i(core_clk_i), .rstn_i(rstn_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .linefeed_state_i(linefeed_state_i),
    .cadence_expire_i(cadence_expire_i), .mode_write_i(mode_write_i),
    .trip_detected_o(trip_detected_o), .exit_req_o(exit_req_o),
    .exit_to_active_o(exit_to_active_o), .force_exit_o(force_exit_o), .irq_o(irq_o));
`default_nettype wire

// >>> ring_trip_defs.vh
// Constants for the ring trip detector: register map, fields, resets, timing
`ifndef RING_TRIP_DEFS_VH
`define RING_TRIP_DEFS_VH

// ==========================================================
// Register word offsets (4-bit index on reg_addr_i)
// ==========================================================
`define REG_CTRL         4'h0
`define REG_AC_THR       4'h1
`define REG_DC_THR       4'h2
`define REG_PERIOD       4'h3
`define REG_AC_DB        4'h4
`define REG_DC_DB        4'h5
`define REG_EXIT_CNT     4'h6
`define REG_IRQ_VEC      4'h7
`define REG_IRQ_EN       4'h8
`define REG_STATUS       4'h9
`define REG_LOOP_CUR     4'hA

// ==========================================================
// Field positions
// ==========================================================
`define CTRL_EXT_BIT     0
`define CTRL_AC_K_LSB    4
`define CTRL_DC_K_LSB    8
`define IRQ_TRIP_BIT     0
`define IRQ_TMO_BIT      1

// ==========================================================
// Reset values
// ==========================================================
`define RST_CTRL         16'h0440
`define RST_THR          16'h7FFF
`define RST_PERIOD       16'h0028
`define RST_DB           16'h0010
`define RST_EXIT_CNT     16'h00A0

// Linefeed state code that means ringing
`define LFS_RINGING      3'h4

// ==========================================================
// Timing: base tick of 1/1600 s, exit LSB is two base ticks
// ==========================================================
`define CLK_PERIOD_NS    8
`define BASE_TICK_NS     625000
`define EXIT_LSB_TICKS   2

`endif

// >>> ring_trip_detector.v
// Ring trip detector: ac and dc trip paths, exit timeout, registers, interrupt
//
// Notes on behaviour
// - Process samples only while linefeed shows ringing
// - Two separately programmable low-pass filters, ac/dc
// - Ac path rectifies before its filter
// - Each filter compared with its own threshold
// - Debounce flips only after full opposite interval
// - Trip detected is OR of both paths
// - Trip raises interrupt when enable bit set
// - Exit timeout counts programmed count times 1.25 ms
// - Cadence expiry exits to on-hook transmission, else active
// - Ringing exit guaranteed within timeout, typically 200 ms
// - Debounce time is count times period over 1600
// - External ringing: dc path uses two sense inputs
// - Pending trip flag in vector, gated by enable
//
// The register addresses and strobed register access are this design's own decisions.
`default_nettype none
`include "ring_trip_defs.vh"

module ring_trip_detector #(
    parameter BASE_CYCLES = `BASE_TICK_NS / `CLK_PERIOD_NS  // 625 us in clocks
) (
    input  wire        core_clk_i,          // 125 MHz core clock
    input  wire        rstn_i,              // Async reset, active low
    input  wire [3:0]  reg_addr_i,          // Register word index
    input  wire [15:0] reg_wdata_i,         // Write data
    input  wire        reg_wr_i,            // Write strobe
    input  wire        reg_rd_i,            // Read strobe
    output wire [15:0] reg_rdata_o,         // Read data, cycle after strobe
    input  wire [15:0] loop_current_sense_i,// Signed loop current sample
    input  wire [15:0] ring_sense_a_i,      // External ring feed sense, side a
    input  wire [15:0] ring_sense_b_i,      // External ring feed sense, side b
    input  wire        sample_valid_i,      // New sample strobe
    input  wire [2:0]  linefeed_state_i,    // Current linefeed state
    input  wire        cadence_expire_i,    // Ringing active timer expired
    input  wire        mode_write_i,        // Manual linefeed mode write
    output wire        trip_detected_o,     // Combined debounced trip
    output wire        exit_req_o,          // Request to leave ringing
    output wire        exit_to_active_o,    // 1: active, 0: on-hook tx
    output wire        force_exit_o,        // Timeout forces the exit
    output wire        irq_o                // Level interrupt
);

    // ==========================================================
    // Helper functions
    // Full-wave rectify with clamp so -32768 cannot wrap
    function [14:0] abs15;
        input [15:0] v;
        begin
            if (v == 16'h8000)
                abs15 = 15'h7FFF;
            else if (v[15])
                abs15 = ~v[14:0] + 15'h0001;
            else
                abs15 = v[14:0];
        end
    endfunction

    // One-pole low-pass: y += (x - y) >>> k
    function [15:0] lpf_step;
        input [15:0] y;
        input [15:0] x;
        input [3:0]  k;
        reg signed [16:0] d;
        begin
            d = $signed({x[15], x}) - $signed({y[15], y});
            d = d >>> k;
            lpf_step = y + d[15:0];
        end
    endfunction

    // Magnitude above threshold; 32767 can never be exceeded
    function over_thr;
        input [15:0] v;
        input [15:0] thr;
        begin
            over_thr = ({1'b0, abs15(v)} > thr);
        end
    endfunction

    // ==========================================================
    // Registers written by software
    reg [15:0] ctrl_ff;          // Mode and filter shifts
    reg [15:0] ac_trip_threshold_ff;
    reg [15:0] dc_trip_threshold_ff;
    reg [15:0] trip_sample_period_ff;
    reg [15:0] ac_debounce_count_ff;
    reg [15:0] dc_debounce_count_ff;
    reg [15:0] exit_timeout_count_ff;
    reg [1:0]  second_irq_vector_ff;  // Sticky events
    reg [1:0]  second_irq_enable_ff;  // Mask of same layout

    // Block state
    reg [15:0] rdata_ff;         // Read data
    reg [15:0] ac_filt_ff;       // Ac filter state
    reg [15:0] dc_filt_ff;       // Dc filter state
    reg [15:0] last_sample_ff;   // Last accepted sample, for readback
    reg [16:0] base_cnt_ff;      // Base tick prescaler
    reg        base_tick_ff;     // One cycle every 625 us
    reg [15:0] per_cnt_ff;       // Debounce unit prescaler
    reg        db_tick_ff;       // Debounce unit strobe
    reg        trip_ff;          // Combined trip, registered
    reg        trip_prev_ff;     // For edge detect
    reg        exiting_ff;       // Exit sequence running
    reg        to_active_ff;     // Exit target
    reg [16:0] exit_cnt_ff;      // Base ticks since exit began
    reg        force_ff;         // Timeout reached
    reg        tmo_evt_ff;       // One-cycle timeout event
    reg        irq_ff;
    wire       ringing;
    wire       ext_mode;
    wire [15:0] ext_sample;
    wire [15:0] dc_input;
    wire       ac_raw;
    wire       dc_raw;
    wire       ac_db;
    wire       dc_db;
    wire       trip_rise;
    wire       wr_vec;
    wire [16:0] exit_limit;
    wire [15:0] per_limit;
    assign ringing    = (linefeed_state_i == `LFS_RINGING);
    assign ext_mode   = ctrl_ff[`CTRL_EXT_BIT];
    // Difference across the ring feed sense resistor
    assign ext_sample = ring_sense_a_i - ring_sense_b_i;
    assign dc_input   = ext_mode ? ext_sample : loop_current_sense_i;
    assign trip_rise  = trip_ff & ~trip_prev_ff;
    assign wr_vec     = reg_wr_i && (reg_addr_i == `REG_IRQ_VEC);
    // Count is in 1.25 ms units, two base ticks each
    assign exit_limit = {exit_timeout_count_ff, 1'b0};
    // Period of zero treated as one to keep ticks alive
    assign per_limit  = (trip_sample_period_ff == 16'h0000) ? 16'h0001
                                                            : trip_sample_period_ff;
    assign reg_rdata_o      = rdata_ff;
    assign trip_detected_o  = trip_ff;
    assign exit_req_o       = exiting_ff;
    assign exit_to_active_o = to_active_ff;
    assign force_exit_o     = force_ff;
    assign irq_o            = irq_ff;
    // ==========================================================
    // Configuration register writes
    always @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            ctrl_ff               <= `RST_CTRL;
            ac_trip_threshold_ff  <= `RST_THR;
            dc_trip_threshold_ff  <= `RST_THR;
            trip_sample_period_ff <= `RST_PERIOD;
            ac_debounce_count_ff  <= `RST_DB;
            dc_debounce_count_ff  <= `RST_DB;
            exit_timeout_count_ff <= `RST_EXIT_CNT;
            second_irq_enable_ff  <= 2'h0;
        end else if (reg_wr_i) begin
            case (reg_addr_i)
                `REG_CTRL:     ctrl_ff               <= reg_wdata_i;
                `REG_AC_THR:   ac_trip_threshold_ff  <= reg_wdata_i;
                `REG_DC_THR:   dc_trip_threshold_ff  <= reg_wdata_i;
                `REG_PERIOD:   trip_sample_period_ff <= reg_wdata_i;
                `REG_AC_DB:    ac_debounce_count_ff  <= reg_wdata_i;
                `REG_DC_DB:    dc_debounce_count_ff  <= reg_wdata_i;
                `REG_EXIT_CNT: exit_timeout_count_ff <= reg_wdata_i;
                `REG_IRQ_EN:   second_irq_enable_ff  <= reg_wdata_i[1:0];
                default: ;  // REG_IRQ_VEC (write-one-to-clear, handled below), read-only or unmapped: no write here
            endcase
        end
    end

    // ==========================================================
    // Read port: data stands in the cycle after the strobe only
    always @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rdata_ff <= 16'h0000;
        end else if (reg_rd_i) begin
            case (reg_addr_i)
                `REG_CTRL:     rdata_ff <= ctrl_ff;
                `REG_AC_THR:   rdata_ff <= ac_trip_threshold_ff;
                `REG_DC_THR:   rdata_ff <= dc_trip_threshold_ff;
                `REG_PERIOD:   rdata_ff <= trip_sample_period_ff;
                `REG_AC_DB:    rdata_ff <= ac_debounce_count_ff;
                `REG_DC_DB:    rdata_ff <= dc_debounce_count_ff;
                `REG_EXIT_CNT: rdata_ff <= exit_timeout_count_ff;
                `REG_IRQ_VEC:  rdata_ff <= {14'h0000, second_irq_vector_ff};
                `REG_IRQ_EN:   rdata_ff <= {14'h0000, second_irq_enable_ff};
                // Live state for monitoring
                `REG_STATUS:   rdata_ff <= {9'h000, linefeed_state_i, force_ff,
                                            exiting_ff, ac_db, dc_db} | {15'h0000, trip_ff};
                `REG_LOOP_CUR: rdata_ff <= last_sample_ff;
                default:       rdata_ff <= 16'h0000;
            endcase
        end else begin
            rdata_ff <= 16'h0000;
        end
    end

    // ==========================================================
    // Time base: 1/1600 s tick, then debounce unit of period ticks
    always @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            base_cnt_ff  <= 17'h0_0000;
            base_tick_ff <= 1'b0;
            per_cnt_ff   <= 16'h0000;
            db_tick_ff   <= 1'b0;
        end else begin
            base_tick_ff <= 1'b0;
            db_tick_ff   <= 1'b0;
            if (base_cnt_ff >= BASE_CYCLES[16:0] - 17'h0_0001) begin
                base_cnt_ff  <= 17'h0_0000;
                base_tick_ff <= 1'b1;
            end else begin
                base_cnt_ff <= base_cnt_ff + 17'h0_0001;
            end
            // Debounce unit = period / 1600 s, so count * unit = time
            if (!ringing) begin
                per_cnt_ff <= 16'h0000;
            end else if (base_tick_ff) begin
                if (per_cnt_ff >= per_limit - 16'h0001) begin
                    per_cnt_ff <= 16'h0000;
                    db_tick_ff <= 1'b1;
                end else begin
                    per_cnt_ff <= per_cnt_ff + 16'h0001;
                end
            end
        end
    end

    // ==========================================================
    // Sample processing and filters
    // Filters are flushed outside ringing so stale current never trips
    always @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            ac_filt_ff     <= 16'h0000;
            dc_filt_ff     <= 16'h0000;
            last_sample_ff <= 16'h0000;
        end else if (!ringing) begin
            ac_filt_ff <= 16'h0000;
            dc_filt_ff <= 16'h0000;
        end else if (sample_valid_i) begin
            last_sample_ff <= loop_current_sense_i;
            // Each path has its own shift
            ac_filt_ff <= lpf_step(ac_filt_ff, {1'b0, abs15(dc_input)},
                                   ctrl_ff[`CTRL_AC_K_LSB +: 4]);
            dc_filt_ff <= lpf_step(dc_filt_ff, dc_input,
                                   ctrl_ff[`CTRL_DC_K_LSB +: 4]);
        end
    end

    // Threshold compares; 32767 disables a path
    assign ac_raw = ringing & over_thr(ac_filt_ff, ac_trip_threshold_ff);
    assign dc_raw = ringing & over_thr(dc_filt_ff, dc_trip_threshold_ff);

    // ==========================================================
    // Debounce stages
    trip_debounce u_ac_db (
        .core_clk_i (core_clk_i),
        .rstn_i     (rstn_i),
        .active_i   (ringing),
        .raw_i      (ac_raw),
        .tick_i     (db_tick_ff),
        .count_i    (ac_debounce_count_ff),
        .out_o      (ac_db)
    );

    trip_debounce u_dc_db (
        .core_clk_i (core_clk_i),
        .rstn_i     (rstn_i),
        .active_i   (ringing),
        .raw_i      (dc_raw),
        .tick_i     (db_tick_ff),
        .count_i    (dc_debounce_count_ff),
        .out_o      (dc_db)
    );

    // ==========================================================
    // Combined trip and exit sequence
    always @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            trip_ff      <= 1'b0;
            trip_prev_ff <= 1'b0;
            exiting_ff   <= 1'b0;
            to_active_ff <= 1'b0;
            exit_cnt_ff  <= 17'h0_0000;
            force_ff     <= 1'b0;
            tmo_evt_ff   <= 1'b0;
        end else begin
            trip_ff      <= ac_db | dc_db;
            trip_prev_ff <= trip_ff;
            tmo_evt_ff   <= 1'b0;
            if (!ringing) begin
                // Ringing left: sequence over
                exiting_ff  <= 1'b0;
                force_ff    <= 1'b0;
                exit_cnt_ff <= 17'h0_0000;
            end else if (!exiting_ff) begin
                // Trip or manual write wins over cadence expiry
                if (trip_rise || mode_write_i) begin
                    exiting_ff   <= 1'b1;
                    to_active_ff <= 1'b1;
                end else if (cadence_expire_i) begin
                    exiting_ff   <= 1'b1;
                    to_active_ff <= 1'b0;
                end
            end else if (!force_ff) begin
                if (exit_cnt_ff >= exit_limit) begin
                    // Mode has not settled in time: force it
                    force_ff   <= 1'b1;
                    tmo_evt_ff <= 1'b1;
                end else if (base_tick_ff) begin
                    exit_cnt_ff <= exit_cnt_ff + 17'h0_0001;
                end
            end
        end
    end

    // ==========================================================
    // Interrupt vector: set wins over write-one-to-clear
    always @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            second_irq_vector_ff <= 2'h0;
            irq_ff               <= 1'b0;
        end else begin
            second_irq_vector_ff[`IRQ_TRIP_BIT] <=
                trip_rise |
                (second_irq_vector_ff[`IRQ_TRIP_BIT] &
                 ~(wr_vec & reg_wdata_i[`IRQ_TRIP_BIT]));
            second_irq_vector_ff[`IRQ_TMO_BIT] <=
                tmo_evt_ff |
                (second_irq_vector_ff[`IRQ_TMO_BIT] &
                 ~(wr_vec & reg_wdata_i[`IRQ_TMO_BIT]));
            // Gated by enable, held while any unmasked bit set
            irq_ff <= |(second_irq_vector_ff & second_irq_enable_ff);
        end
    end

endmodule

`default_nettype wire

// >>> tb_ring_trip_detector.sv
// Self-checking bench for the ring trip detector
`default_nettype none
`include "ring_trip_defs.vh"
`define CHK(nm, ex, gt) begin n_checks++; if ((gt) !== (ex)) begin \
    $display("BAD %s exp %h got %h", nm, ex, gt); err_count++; end end
module tb_ring_trip_detector;
    timeunit 1ns;
    timeprecision 1ps;
    logic        core_clk_i = 0;
    logic        rstn_i     = 0;
    logic [3:0]  reg_addr_i = '0;
    logic [15:0] reg_wdata_i = '0;
    logic        reg_wr_i = 0, reg_rd_i = 0, sample_valid_i = 0;
    logic        cadence_expire_i = 0, mode_write_i = 0;
    logic [15:0] loop_current_sense_i = '0, ring_sense_a_i = '0, ring_sense_b_i = '0;
    logic [2:0]  linefeed_state_i = '0;
    wire  [15:0] reg_rdata_o;
    wire         trip_detected_o, exit_req_o, exit_to_active_o, force_exit_o, irq_o;
    int          err_count = 0, n_checks = 0;
    logic [15:0] rv;                         // Last read word
    always #4 core_clk_i = ~core_clk_i;      // 125 MHz
    // Short base tick keeps debounce and timeout runs brief
    ring_trip_detector #(.BASE_CYCLES(4)) dut_u (.core_clk_i(core_clk_i), .rstn_i(rstn_i),
        .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
        .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
        .loop_current_sense_i(loop_current_sense_i), .ring_sense_a_i(ring_sense_a_i),
        .ring_sense_b_i(ring_sense_b_i), .sample_valid_i(sample_valid_i),
        .linefeed_state_i(linefeed_state_i), .cadence_expire_i(cadence_expire_i),
        .mode_write_i(mode_write_i), .trip_detected_o(trip_detected_o),
        .exit_req_o(exit_req_o), .exit_to_active_o(exit_to_active_o),
        .force_exit_o(force_exit_o), .irq_o(irq_o));
    // ==========
    // Bus and stimulus helpers
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge core_clk_i);
        reg_wr_i    <= 1'b1;
        reg_addr_i  <= a;
        reg_wdata_i <= d;
        @(posedge core_clk_i);
        reg_wr_i    <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a);
        @(posedge core_clk_i);
        reg_rd_i   <= 1'b1;
        reg_addr_i <= a;
        @(posedge core_clk_i);
        reg_rd_i   <= 1'b0;
        #1 rv = reg_rdata_o;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk_i);
        #1;
    endtask
    task automatic drive(input logic [2:0] lfs, input logic [15:0] cur, a, b);
        @(posedge core_clk_i);
        linefeed_state_i     <= lfs;
        loop_current_sense_i <= cur;
        ring_sense_a_i       <= a;
        ring_sense_b_i       <= b;
    endtask
    // Opposite-sign samples: only a rectified path averages away from zero
    task automatic alt(input int n);
        repeat (n) begin
            @(posedge core_clk_i);
            loop_current_sense_i <= (loop_current_sense_i == 16'h01F4) ? 16'hFE0C : 16'h01F4;
        end
    endtask
    task automatic pulse(input bit cad);
        @(posedge core_clk_i);
        cadence_expire_i <= cad;
        mode_write_i     <= !cad;
        @(posedge core_clk_i);
        cadence_expire_i <= 1'b0;
        mode_write_i     <= 1'b0;
    endtask
    // Bounded wait: 0 trip, 1 forced exit
    task automatic wait_hi(input int sel, input int bound);
        int i;
        for (i = 0; i < bound; i++) begin
            if ((sel == 0 ? trip_detected_o : force_exit_o) === 1'b1) break;
            cyc(1);
        end
        if (i == bound) begin
            err_count++;
            $display("BAD wait %0d exp 1 got 0", sel);
            end_of_test();
        end
    endtask
    // ==========
    // Scenarios
    task automatic t_regs();
        rd(`REG_AC_THR);
        `CHK("ac_thr", 16'h7FFF, rv)
        rd(`REG_EXIT_CNT);
        `CHK("exit_cnt", 16'h00A0, rv)
        rd(`REG_DC_DB);
        `CHK("dc_db", 16'h0010, rv)
        rd(4'hF);
        `CHK("unmapped", 16'h0000, rv)
        $display("t_regs done");
    endtask
    task automatic t_ac();
        wr(`REG_PERIOD, 16'h0001);
        wr(`REG_AC_DB, 16'h0002);
        wr(`REG_AC_THR, 16'h0064);
        wr(`REG_DC_THR, 16'h0064);
        wr(`REG_IRQ_EN, 16'h0001);
        drive(`LFS_RINGING, 16'h01F4, 16'h0000, 16'h0000);
        alt(40);
        wait_hi(0, 60);
        cyc(3);
        rd(`REG_STATUS);
        `CHK("ac_db", 1'b1, rv[1])
        `CHK("irq", 1'b1, irq_o)
        `CHK("to_active", 2'b11, {exit_req_o, exit_to_active_o})
        rd(`REG_IRQ_VEC);
        `CHK("vec", 16'h0001, rv)
        wr(`REG_IRQ_VEC, 16'h0001);
        rd(`REG_IRQ_VEC);
        `CHK("vec_clr", 16'h0000, rv)
        `CHK("irq_clr", 1'b0, irq_o)
        drive(3'h0, 16'h0000, 16'h0000, 16'h0000);
        cyc(3);
        `CHK("trip_off", 1'b0, trip_detected_o)
        $display("t_ac done");
    endtask
    task automatic t_ext();
        wr(`REG_CTRL, 16'h0001);     // Sense inputs, no filter lag
        wr(`REG_AC_THR, 16'h7FFF);   // Ac path off
        wr(`REG_DC_DB, 16'h0005);    // Five ticks of four clocks
        drive(3'h0, 16'h0000, 16'h0258, 16'h0064);
        cyc(60);
        `CHK("no_ring", 1'b0, trip_detected_o)
        drive(`LFS_RINGING, 16'h0000, 16'h0258, 16'h0064);
        cyc(8);
        drive(`LFS_RINGING, 16'h0000, 16'h0064, 16'h0064);
        cyc(30);
        `CHK("glitch", 1'b0, trip_detected_o)
        drive(`LFS_RINGING, 16'h0000, 16'h0258, 16'h0064);
        cyc(20);                     // Just short of the full interval
        `CHK("early", 1'b0, trip_detected_o)
        wait_hi(0, 40);
        `CHK("ext_trip", 1'b1, trip_detected_o)
        drive(3'h0, 16'h0000, 16'h0000, 16'h0000);
        $display("t_ext done");
    endtask
    task automatic t_cad();
        wr(`REG_EXIT_CNT, 16'h0002); // Four base ticks
        wr(`REG_IRQ_EN, 16'h0000);
        drive(`LFS_RINGING, 16'h0000, 16'h0000, 16'h0000);
        pulse(1);
        pulse(0);                    // Ignored: exit already running
        cyc(1);
        `CHK("onhook", 2'b10, {exit_req_o, exit_to_active_o})
        cyc(3);
        `CHK("force_early", 1'b0, force_exit_o)
        wait_hi(1, 30);
        cyc(2);
        rd(`REG_IRQ_VEC);
        `CHK("vec_tmo", 1'b1, rv[1])
        `CHK("masked", 1'b0, irq_o)
        wr(`REG_IRQ_EN, 16'h0002);
        cyc(2);
        `CHK("unmasked", 1'b1, irq_o)
        wr(`REG_IRQ_VEC, 16'h0002);
        cyc(2);
        `CHK("cleared", 1'b0, irq_o)
        drive(3'h0, 16'h0000, 16'h0000, 16'h0000);
        drive(`LFS_RINGING, 16'h0000, 16'h0000, 16'h0000);
        pulse(0);
        cyc(1);
        `CHK("manual", 2'b11, {exit_req_o, exit_to_active_o})
        $display("t_cad done");
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    initial begin
        repeat (10) @(posedge core_clk_i);
        rstn_i         <= 1'b1;
        sample_valid_i <= 1'b1;
        t_regs();
        t_ac();
        t_ext();
        t_cad();
        end_of_test();
    end
endmodule
`default_nettype wire

// >>> trip_debounce.v
// Debounce stage: output flips only after raw input disagrees for a full interval
`default_nettype none

module trip_debounce (
    input  wire        core_clk_i,   // Core clock
    input  wire        rstn_i,       // Async reset, active low
    input  wire        active_i,     // Path running (ringing)
    input  wire        raw_i,        // Raw threshold result
    input  wire        tick_i,       // Debounce time unit
    input  wire [15:0] count_i,      // Interval in ticks
    output wire        out_o         // Debounced result
);

    // ==========================================================
    // State
    // ==========================================================
    reg        out_ff;               // Held output
    reg [15:0] cnt_ff;               // Ticks spent in opposite state
    reg        nxt_out;
    reg [15:0] nxt_cnt;

    assign out_o = out_ff;

    // ==========================================================
    // Next state: any agreement restarts the interval
    // ==========================================================
    always @* begin
        nxt_out = out_ff;
        nxt_cnt = cnt_ff;
        if (!active_i) begin
            // Cleared outside ringing so a new ring starts clean
            nxt_out = 1'b0;
            nxt_cnt = 16'h0000;
        end else if (raw_i == out_ff) begin
            nxt_cnt = 16'h0000;
        end else if (tick_i && (cnt_ff >= count_i)) begin
            // Flip one tick late: the first tick may land early, never short
            nxt_out = raw_i;
            nxt_cnt = 16'h0000;
        end else if (tick_i) begin
            nxt_cnt = cnt_ff + 16'h0001;
        end
    end

    // Registers
    always @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            out_ff <= 1'b0;
            cnt_ff <= 16'h0000;
        end else begin
            out_ff <= nxt_out;
            cnt_ff <= nxt_cnt;
        end
    end

endmodule

`default_nettype wire
